// File: sfp_top.sv
// Serial flash page operations and status read: package and top module.
// Assumes host pins arrive asynchronously and an array model outside
// reacts to op_req_out and reports the compare mismatch.

package sfp_pkg;
  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OPC_COPY_B1 = 8'h53;
  localparam logic [7:0] OPC_COPY_B2 = 8'h55;
  localparam logic [7:0] OPC_COMP_B1 = 8'h60;
  localparam logic [7:0] OPC_COMP_B2 = 8'h61;
  localparam logic [7:0] OPC_REWR_B1 = 8'h58;
  localparam logic [7:0] OPC_REWR_B2 = 8'h59;
  localparam logic [7:0] OPC_STATUS  = 8'hd7;

  // ==========================================================================
  // Frame layout
  localparam logic [4:0] OPC_LAST_BIT  = 5'h07;
  localparam logic [4:0] ADDR_BITS     = 5'h18;
  localparam int         PG528_LSB     = 10;
  localparam int         PG512_LSB     = 9;
  localparam logic [3:0] STAT_LAST_BIT = 4'hf;

  // ==========================================================================
  // Timing: durations in ns, cycle counts derived from the clock period
  localparam int unsigned CLK_PERIOD_NS      = 5;
  localparam int unsigned PAGE_COPY_TIME_NS  = 200000;
  localparam int unsigned MATCH_CHECK_TIME_NS = 200000;
  localparam int unsigned REWRITE_MAX_TIME_NS = 20000000;
  localparam int unsigned COPY_CYC_DEF = PAGE_COPY_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned COMP_CYC_DEF = MATCH_CHECK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned REWR_CYC_DEF = REWRITE_MAX_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {OP_COPY, OP_COMPARE, OP_REWRITE} sfp_op_e;

  typedef struct packed {
    sfp_op_e     kind;       // Operation to run
    logic        buf_two;    // 1 selects the second buffer
    logic [12:0] page;       // page_number_bits
  } sfp_op_req_s;

  typedef struct packed {
    logic protect;                 // Sector protection enabled
    logic page_pow2;               // 512-byte page configuration
    logic program_error_flag;
    logic lockdown_enable_flag;
    logic buffer_two_suspend_flag;
    logic buffer_one_suspend_flag;
    logic erase_suspend_flag;
  } sfp_flags_s;
endpackage

`timescale 1ns/100ps
`default_nettype none

module sfp_top #(
  parameter int unsigned COPY_CYC     = sfp_pkg::COPY_CYC_DEF,
  parameter int unsigned COMP_CYC     = sfp_pkg::COMP_CYC_DEF,
  parameter int unsigned REWR_CYC     = sfp_pkg::REWR_CYC_DEF,
  parameter logic [3:0]  DENSITY_CODE = 4'h5  // Arbitrary value
) (
  input  wire logic                 clk_in,       // 200 MHz clock
  input  wire logic                 nrst_in,      // Async reset, active low
  input  wire logic                 cs_n_in,      // Chip select pin
  input  wire logic                 sck_in,       // Serial clock pin
  input  wire logic                 si_in,        // Serial data in pin
  input  wire sfp_pkg::sfp_flags_s  flags_in,     // Status flags, same clock
  input  wire logic                 mismatch_in,  // Compare result from array
  output logic                      so_out,       // Serial data out
  output logic                      so_oe_n_out,  // Low while driving so_out
  output logic                      op_start_out, // One-cycle launch pulse
  output sfp_pkg::sfp_op_req_s      op_req_out    // Launched operation
);
  import sfp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_ARMED, ST_STAT, ST_SKIP
  } sfp_fsm_e;

  typedef struct packed {
    logic [2:0]  cs_sy;     // [0] first flop, [1] second, [2] previous
    logic [2:0]  sck_sy;
    logic [1:0]  si_sy;
    sfp_fsm_e    st;
    logic [4:0]  cnt;
    logic [7:0]  opc;
    logic [23:0] addr;
    logic [3:0]  sbit;
    logic        so;
    logic        so_oe_n;
    logic        comp;
    logic        start;
    sfp_op_req_s pend;     // Kept apart so a refused command leaves req alone
    sfp_op_req_s req;
  } sfp_state_s;

  // ==========================================================================
  // Reset release
  logic [1:0] rst_q;
  logic       rst_n;

  // Reset is applied at once but released through two flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ==========================================================================
  // Self-timed operation timer
  sfp_state_s r;
  sfp_state_s next_r;
  logic       busy;
  logic       done;

  sfp_op_timer #(
    .COPY_CYC (COPY_CYC),
    .COMP_CYC (COMP_CYC),
    .REWR_CYC (REWR_CYC)
  ) u_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .start_in (r.start),
    .kind_in  (r.req.kind),
    .busy_out (busy),
    .done_out (done)
  );

  // ==========================================================================
  // Helpers
  // Page field sits one bit lower in the 512-byte layout
  function automatic logic [12:0] page_of(input logic [23:0] a,
                                          input logic        pow2);
    page_of = pow2 ? a[PG512_LSB +: 13] : a[PG528_LSB +: 13];
  endfunction

  // Status bit at position i of the repeating 16-bit stream, MSB first
  function automatic logic stat_bit(input logic [3:0] i,
                                    input logic       rdy,
                                    input logic       comp,
                                    input sfp_flags_s f,
                                    input logic [3:0] dens);
    logic [15:0] w;
    w = {rdy, comp, dens, f.protect, f.page_pow2,
         rdy, 1'b0, f.program_error_flag, 1'b0,
         f.lockdown_enable_flag, f.buffer_two_suspend_flag,
         f.buffer_one_suspend_flag, f.erase_suspend_flag};
    stat_bit = w[4'hf - i];
  endfunction

  // ==========================================================================
  // State and next state
  logic       cs_rise;
  logic       cs_fall;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] opc_in;

  // Edges look only at the second and third sync stages
  assign cs_rise  = r.cs_sy[1] & ~r.cs_sy[2];
  assign cs_fall  = ~r.cs_sy[1] & r.cs_sy[2];
  assign sck_rise = r.sck_sy[1] & ~r.sck_sy[2];
  assign sck_fall = ~r.sck_sy[1] & r.sck_sy[2];
  assign opc_in   = {r.opc[6:0], r.si_sy[1]};

  // Command decoder, address capture and status shifter
  always_comb begin
    next_r        = r;
    next_r.start  = 1'b0;
    next_r.cs_sy  = {r.cs_sy[1:0], cs_n_in};
    next_r.sck_sy = {r.sck_sy[1:0], sck_in};
    next_r.si_sy  = {r.si_sy[0], si_in};
    if (done && r.req.kind == OP_COMPARE) begin
      next_r.comp = mismatch_in;
    end
    if (cs_rise) begin
      next_r.st      = ST_IDLE;
      next_r.so_oe_n = 1'b1;
      // A command arriving while busy is dropped, not queued
      if (r.st == ST_ARMED && !busy) begin
        next_r.start    = 1'b1;
        next_r.req      = r.pend;
        next_r.req.page = page_of(r.addr, flags_in.page_pow2);
      end
    end else if (cs_fall) begin
      next_r.st  = ST_CMD;
      next_r.cnt = 5'h00;
    end else begin
      case (r.st)
        ST_CMD: begin
          if (sck_rise) begin
            next_r.opc = opc_in;
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt == OPC_LAST_BIT) begin
              next_r.cnt = 5'h00;
              case (opc_in)
                OPC_STATUS: begin
                  next_r.st   = ST_STAT;
                  next_r.sbit = 4'h0;
                end
                OPC_COPY_B1, OPC_COPY_B2: begin
                  next_r.st        = ST_ADDR;
                  next_r.pend.kind = OP_COPY;
                end
                OPC_COMP_B1, OPC_COMP_B2: begin
                  next_r.st        = ST_ADDR;
                  next_r.pend.kind = OP_COMPARE;
                end
                OPC_REWR_B1, OPC_REWR_B2: begin
                  next_r.st        = ST_ADDR;
                  next_r.pend.kind = OP_REWRITE;
                end
                default: begin
                  next_r.st = ST_SKIP;
                end
              endcase
              // Copy pair differs in bits 1 and 2, the others in bit 0
              next_r.pend.buf_two = opc_in[0] & (opc_in != OPC_COPY_B1);
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            next_r.addr = {r.addr[22:0], r.si_sy[1]};
            next_r.cnt  = r.cnt + 5'h01;
            if (r.cnt == ADDR_BITS - 5'h01) begin
              next_r.st = ST_ARMED;
            end
          end
        end
        ST_STAT: begin
          // Values are read live at every bit, so each byte is current
          if (sck_fall) begin
            next_r.so      = stat_bit(r.sbit, ~busy, r.comp, flags_in,
                                      DENSITY_CODE);
            next_r.so_oe_n = 1'b0;
            next_r.sbit    = r.sbit + 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      r         <= '0;
      r.cs_sy   <= 3'h7;
      r.sck_sy  <= 3'h0;
      r.so_oe_n <= 1'b1;
      r.st      <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign so_out       = r.so;
  assign so_oe_n_out  = r.so_oe_n;
  assign op_start_out = r.start;
  assign op_req_out   = r.req;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_launch(sfp_op_e k);
    r.start && r.req.kind == k;
  endsequence

  a_launch_on_cs: assert property (r.start |-> $past(cs_rise))
    else $error("launch without chip select rise");

  a_copy_opcode: assert property (s_launch(OP_COPY) |->
      (r.opc == OPC_COPY_B1 && !r.req.buf_two) ||
      (r.opc == OPC_COPY_B2 && r.req.buf_two))
    else $error("copy launched with wrong opcode or buffer");

  a_compare_opcode: assert property (s_launch(OP_COMPARE) |->
      r.opc[7:1] == OPC_COMP_B1[7:1] && r.req.buf_two == r.opc[0])
    else $error("compare launched with wrong opcode or buffer");

  a_rewrite_opcode: assert property (s_launch(OP_REWRITE) |->
      r.opc[7:1] == OPC_REWR_B1[7:1] && r.req.buf_two == r.opc[0])
    else $error("rewrite launched with wrong opcode or buffer");

  a_page_select: assert property (r.start |->
      r.req.page == ($past(flags_in.page_pow2) ? r.addr[21:9]
                                               : r.addr[22:10]))
    else $error("page number taken from wrong address bits");

  a_op_busy: assert property (r.start |=> busy [*2])
    else $error("operation not shown busy");

  a_comp_result: assert property (
      done && r.req.kind == OP_COMPARE |=> r.comp == $past(mismatch_in))
    else $error("compare result not stored");

  a_status_enter: assert property (
      r.st == ST_CMD && sck_rise && r.cnt == OPC_LAST_BIT &&
      opc_in == OPC_STATUS && !cs_rise && !cs_fall |=> r.st == ST_STAT)
    else $error("status opcode not accepted");

  a_status_wrap: assert property (
      r.st == ST_STAT && sck_fall && r.sbit == STAT_LAST_BIT && !cs_rise
      && !cs_fall |=> r.sbit == 4'h0)
    else $error("status stream did not wrap");

  a_ready_bit: assert property (
      r.st == ST_STAT && sck_fall && r.sbit[2:0] == 3'h0 && !cs_rise
      && !cs_fall |=> !r.so_oe_n && r.so == $past(!busy))
    else $error("ready bit stale or wrong");

  a_cs_release_hiz: assert property (cs_rise |=> r.so_oe_n)
    else $error("output still driven after chip select rise");
endmodule

`default_nettype wire

// File: sfp_op_timer.sv
// Self-timed operation timer for page copy, compare and rewrite.
// Assumes start_in is a one-cycle pulse from the same clock domain.

`timescale 1ns/100ps
`default_nettype none

module sfp_op_timer #(
  parameter int unsigned COPY_CYC = sfp_pkg::COPY_CYC_DEF,
  parameter int unsigned COMP_CYC = sfp_pkg::COMP_CYC_DEF,
  parameter int unsigned REWR_CYC = sfp_pkg::REWR_CYC_DEF
) (
  input  wire logic            clk_in,   // System clock
  input  wire logic            rst_n_in, // Synchronised reset, active low
  input  wire logic            start_in, // Launch pulse
  input  wire sfp_pkg::sfp_op_e kind_in, // Operation to time
  output logic                 busy_out, // High while operation runs
  output logic                 done_out  // One-cycle pulse at completion
);
  import sfp_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [31:0] cnt;
  } sfp_tmr_s;

  sfp_tmr_s r;
  sfp_tmr_s next_r;

  // Rewrite is timed as one span covering its copy and program phases
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start_in && !r.busy) begin
      next_r.busy = 1'b1;
      case (kind_in)
        OP_COPY:    next_r.cnt = 32'(COPY_CYC) - 32'h1;
        OP_COMPARE: next_r.cnt = 32'(COMP_CYC) - 32'h1;
        OP_REWRITE: next_r.cnt = 32'(REWR_CYC) - 32'h1;
        default:    next_r.cnt = 32'h0;
      endcase
    end else if (r.busy) begin
      if (r.cnt == 32'h0) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 32'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy_out = r.busy;
  assign done_out = r.done;
endmodule

`default_nettype wire

// File: sfp_host_model.sv
// Host serial controller model: drives chip select, link clock and data.
// Assumes the caller owns clk_in and calls xfer from one process at a time.

`timescale 1ns/100ps
`default_nettype none

module sfp_host_model #(
  parameter int HALF_CYC = 16  // 80 ns half period at 5 ns clk_in
) (
  input  wire logic clk_in,    // Bench clock, paces the link clock
  input  wire logic so_in,     // Serial data from the device
  output var  logic cs_n_out,  // Chip select, active low
  output var  logic sck_out,   // Link clock, idles low
  output var  logic si_out     // Serial data to the device
);
  // ==========================================================================
  // Idle state: link clock stands still between frames
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end

  task automatic half();
    repeat (HALF_CYC) @(posedge clk_in);
  endtask

  // One frame: opcode, n_in address bits, then n_out bits read back.
  // Data line toggles when not carrying bits, so a stale value never helps
  task automatic xfer(input logic [7:0] opc, input logic [23:0] addr,
                      input int n_in, input int n_out,
                      output logic [31:0] rx);
    logic [31:0] tx;
    rx = '0;
    tx = {opc, addr};
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    half();
    for (int i = 0; i < 8 + n_in; i++) begin
      si_out <= tx[31-i];
      half();
      sck_out <= 1'b1;
      half();
      sck_out <= 1'b0;
    end
    for (int i = 0; i < n_out; i++) begin
      si_out <= ~si_out;
      half();
      sck_out <= 1'b1;
      rx = {rx[30:0], so_in};
      half();
      sck_out <= 1'b0;
    end
    half();
    cs_n_out <= 1'b1;
    si_out <= ~si_out;
    // Keep chip select high long enough for the device to see the rise
    half();
  endtask
endmodule

`default_nettype wire

// File: tb.sv
// Testbench for sfp_top: status stream, page operations, a refused short command.
// Assumes sfp_pkg and sfp_top are compiled first; host model drives link.

`timescale 1ns/100ps
`default_nettype none

module tb;
  import sfp_pkg::*;
  localparam int         OP_CYC = 600;   // Long enough to poll busy
  localparam logic [3:0] DENS   = 4'h6;  // Arbitrary density code

  logic         clk_in = 1'b0;
  logic         nrst_in;
  sfp_flags_s   flags_in;
  logic         mismatch_in;
  wire logic    cs_n, sck, si;
  logic         so_out, so_oe_n_out, op_start_out;
  sfp_op_req_s  op_req_out;
  logic         comp_exp = 1'b0;
  int           n_fail = 0;
  int           checked = 0;
  int           n_start = 0;

  always #2.5 clk_in = ~clk_in;

  sfp_top #(.COPY_CYC(OP_CYC), .COMP_CYC(OP_CYC), .REWR_CYC(2 * OP_CYC),
            .DENSITY_CODE(DENS)) i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .flags_in(flags_in), .mismatch_in(mismatch_in),
    .so_out(so_out), .so_oe_n_out(so_oe_n_out),
    .op_start_out(op_start_out), .op_req_out(op_req_out));

  sfp_host_model i_host (
    .clk_in(clk_in), .so_in(so_out), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si));

  // Count launches; a missed or doubled pulse shows in the count
  always @(posedge clk_in) if (op_start_out === 1'b1) n_start <= n_start + 1;

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] st(input logic rdy);
    return {rdy, comp_exp, DENS, flags_in.protect, flags_in.page_pow2,
            rdy, 1'b0, flags_in.program_error_flag, 1'b0,
            flags_in.lockdown_enable_flag, flags_in.buffer_two_suspend_flag,
            flags_in.buffer_one_suspend_flag, flags_in.erase_suspend_flag};
  endfunction

  task automatic summarize();
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Two full status bytes twice over, then a cut-short read
  task automatic stat_test(input sfp_flags_s f);
    logic [31:0] rx;
    flags_in <= f;
    i_host.xfer(OPC_STATUS, 24'h0, 0, 32, rx);
    chk("status stream", {2{st(1'b1)}}, rx);
    i_host.xfer(OPC_STATUS, 24'h0, 0, 5, rx);
    chk("partial status", {16'h0, st(1'b1) >> 11}, rx);
    repeat (8) @(posedge clk_in);
    chk("output released", 32'h1, so_oe_n_out);
  endtask

  // Launch one operation, see busy while it runs, poll until ready.
  // Dummy address bits are ones so a misplaced slice shows in the page
  task automatic run_op(input logic [7:0] opc, input sfp_op_e kind,
                        input logic b2, input logic pow2,
                        input logic [12:0] pg, input logic mis);
    logic [31:0] rx;
    logic [23:0] a;
    sfp_op_req_s exp;
    int n0;
    flags_in.page_pow2 <= pow2;
    mismatch_in <= mis;
    a = pow2 ? {2'b11, pg, 9'h1ff} : {1'b1, pg, 10'h3ff};
    exp = '{kind: kind, buf_two: b2, page: pg};
    n0 = n_start;
    i_host.xfer(opc, a, 24, 0, rx);
    i_host.xfer(OPC_STATUS, 24'h0, 0, 8, rx);
    chk("launch count", n0 + 1, n_start);
    chk("request", exp, op_req_out);
    chk("busy flag", 32'h0, rx[7]);
    if (kind == OP_COMPARE) comp_exp = mis;
    rx = '0;
    for (int i = 0; i < 8 && rx[7] !== 1'b1; i++) begin
      i_host.xfer(OPC_STATUS, 24'h0, 0, 8, rx);
    end
    chk("ready status", st(1'b1) >> 8, rx[7:0]);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] rx;
    nrst_in = 1'b0;
    flags_in = '0;
    mismatch_in = 1'b0;
    repeat (12) @(posedge clk_in);
    chk("reset outputs", 32'h20000,
        {so_oe_n_out, op_start_out, op_req_out});
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    stat_test(7'h55);
    stat_test(7'h2a);
    // Chip select rises after 16 address bits: nothing may launch
    i_host.xfer(OPC_COPY_B1, 24'hffffff, 16, 0, rx);
    i_host.xfer(OPC_STATUS, 24'h0, 0, 8, rx);
    chk("short command", 32'h0, n_start);
    chk("still ready", 32'h1, rx[7]);
    run_op(OPC_COPY_B1, OP_COPY, 1'b0, 1'b0, 13'h1555, 1'b0);
    run_op(OPC_COPY_B2, OP_COPY, 1'b1, 1'b1, 13'h0aaa, 1'b0);
    run_op(OPC_COMP_B1, OP_COMPARE, 1'b0, 1'b1, 13'h1fff, 1'b1);
    run_op(OPC_COMP_B2, OP_COMPARE, 1'b1, 1'b0, 13'h0001, 1'b0);
    run_op(OPC_REWR_B1, OP_REWRITE, 1'b0, 1'b0, 13'h0000, 1'b1);
    run_op(OPC_REWR_B2, OP_REWRITE, 1'b1, 1'b1, 13'h1000, 1'b0);
    summarize();
  end

  // Watchdog: the sequence needs about 100 us; this leaves ample margin
  initial begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule

`default_nettype wire
